// ==== core/tlpca_regs.vh ====
// Purpose: constants for the transmit link arbiter and channel assigner
// Assumes: 32 links, 32 time-slots per link, 1024-word provisioning memory
// Notes:   definitions only
`ifndef TLPCA_REGS_VH
`define TLPCA_REGS_VH

`define TLPCA_NLINK        32
`define TLPCA_LINK_W       5
`define TLPCA_SLOT_W       5
`define TLPCA_ADDR_W       10
`define TLPCA_DEPTH        1024
`define TLPCA_CHAN_W       8
`define TLPCA_WORD_W       9
`define TLPCA_EN_BIT       8
`define TLPCA_NULL_PERIOD  2'h3
`define TLPCA_RST_WORD     9'h000

`endif

// ==== core/tlpca_core.v ====
// Purpose: fixed-priority arbiter and channel lookup for the transmit links
// Assumes: request, slot and config inputs synchronous to i_clk unless noted
// Notes:   link requests are synchronised; config access only in null cycles
`include "tlpca_regs.vh"

// What this block does
// - every link request passes a two-stage synchroniser before arbitration.
// - fixed priority grants the lowest-numbered requesting link first.
// - a cycle with no pending request grants no link.
// - one cycle in four is a null cycle that grants nothing.
// - config-bus reads and writes of the provisioning memory happen only in null cycles.
// - the stage after arbitration looks up the channel of each granted byte.
// - the provisioning memory holds 1024 words.
// - the memory address is the granted link joined with its current time-slot.
// - each word holds a channel number and a time-slot enable flag.
// - an enabled slot issues a data request carrying the channel to the HDLC processor.
module tlpca_core (
    input  wire         i_clk,
    input  wire         i_rstn,
    input  wire [31:0]  i_link_req,
    input  wire [159:0] i_link_slot,
    input  wire         i_cfg_req,
    input  wire         i_cfg_wr,
    input  wire [9:0]   i_cfg_addr,
    input  wire [8:0]   i_cfg_wdata,
    input  wire [7:0]   i_fill_byte,
    input  wire         i_hdlc_valid,
    input  wire [7:0]   i_hdlc_byte,
    output reg          o_cfg_ack,
    output reg  [8:0]   o_cfg_rdata,
    output reg  [31:0]  o_link_grant,
    output reg          o_hdlc_req,
    output reg  [7:0]   o_hdlc_chan,
    output reg          o_link_load,
    output reg  [4:0]   o_link_num,
    output reg  [7:0]   o_link_byte
);

// ----------------------------------------
// reset release
// ----------------------------------------
reg rst_meta_q;
reg rst_sync_q;
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        rst_meta_q <= 1'b0;
        rst_sync_q <= 1'b0;
    end else begin
        rst_meta_q <= 1'b1;
        rst_sync_q <= rst_meta_q;
    end
end
wire rstn = rst_sync_q;

// ----------------------------------------
// request synchronisers
// ----------------------------------------
wire [31:0] req_rise;
wire [31:0] pend;
reg  [31:0] win_mask;
genvar      g;

generate
    for (g = 0; g < `TLPCA_NLINK; g = g + 1) begin : g_link
        reg req_meta_q;
        reg req_sync_q;
        reg req_last_q;
        reg pend_q;
        // held level served once per rising edge
        always @(posedge i_clk or negedge rstn) begin
            if (!rstn) begin
                req_meta_q <= 1'b0;
                req_sync_q <= 1'b0;
                req_last_q <= 1'b0;
                pend_q     <= 1'b0;
            end else begin
                req_meta_q <= i_link_req[g];
                req_sync_q <= req_meta_q;
                req_last_q <= req_sync_q;
                pend_q     <= pend[g] & ~win_mask[g];
            end
        end
        assign req_rise[g] = req_sync_q & ~req_last_q;
        assign pend[g]     = pend_q | req_rise[g];
    end
endgenerate

// ----------------------------------------
// null cycle phase
// ----------------------------------------
reg [1:0] phase_q;
wire      null_cyc = (phase_q == `TLPCA_NULL_PERIOD);
always @(posedge i_clk or negedge rstn) begin
    if (!rstn)
        phase_q <= 2'h0;
    else
        phase_q <= phase_q + 2'h1;
end

// ----------------------------------------
// priority pick
// ----------------------------------------
// lowest-numbered pending link wins
reg  [4:0]  win;
reg         any;
integer     k;
always @* begin
    win = 5'h0;
    any = 1'b0;
    for (k = 31; k >= 0; k = k - 1) begin
        if (pend[k]) begin
            win = k[4:0];
            any = 1'b1;
        end
    end
end
// null cycle overrides any pending link
wire grant = any && !null_cyc;
always @* begin
    win_mask = 32'h0;
    win_mask[win] = grant;
end

// ----------------------------------------
// provisioning memory
// ----------------------------------------
reg [8:0] prov_mem [0:1023];
wire [4:0] win_slot = i_link_slot[win*5 +: 5];
wire [9:0] look_addr = {win, win_slot};
reg [8:0] look_q;
reg       look_vld_q;
reg [4:0] look_link_q;
// config port owns the memory only in the null cycle
wire       cfg_take  = null_cyc && i_cfg_req;
wire       cfg_write = cfg_take && i_cfg_wr;
wire [9:0] mem_addr  = null_cyc ? i_cfg_addr : look_addr;
always @(posedge i_clk) begin
    if (cfg_write)
        prov_mem[i_cfg_addr] <= i_cfg_wdata;
    look_q <= prov_mem[mem_addr];
end

// ----------------------------------------
// grant, lookup and answer stages
// ----------------------------------------
always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
        o_link_grant <= 32'h0;
        look_vld_q   <= 1'b0;
        look_link_q  <= 5'h0;
    end else begin
        o_link_grant <= win_mask;
        look_vld_q   <= grant;
        look_link_q  <= win;
    end
end

// ----------------------------------------
// config access answer
// ----------------------------------------
// read data one cycle after the ack
reg cfg_rd_q;

always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
        cfg_rd_q    <= 1'b0;
        o_cfg_ack   <= 1'b0;
        o_cfg_rdata <= `TLPCA_RST_WORD;
    end else begin
        cfg_rd_q  <= cfg_take && !i_cfg_wr;
        o_cfg_ack <= cfg_take;
        if (cfg_rd_q)
            o_cfg_rdata <= look_q;
    end
end

// ----------------------------------------
// data request and link load
// ----------------------------------------
// link waiting on the hdlc answer
reg [4:0] hdlc_link_q;
reg       hdlc_wait_q;

always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
        o_hdlc_req  <= 1'b0;
        o_hdlc_chan <= 8'h0;
        hdlc_link_q <= 5'h0;
        hdlc_wait_q <= 1'b0;
        o_link_load <= 1'b0;
        o_link_num  <= 5'h0;
        o_link_byte <= 8'h0;
    end else begin
        o_hdlc_req  <= 1'b0;
        o_link_load <= 1'b0;
        if (look_vld_q) begin
            if (look_q[`TLPCA_EN_BIT]) begin
                o_hdlc_req  <= 1'b1;
                o_hdlc_chan <= look_q[7:0];
                hdlc_link_q <= look_link_q;
                hdlc_wait_q <= 1'b1;
            end else begin
                o_link_load <= 1'b1;
                o_link_num  <= look_link_q;
                o_link_byte <= i_fill_byte;
            end
        end else if (i_hdlc_valid && hdlc_wait_q) begin
            // answer goes to the link that asked for it
            o_link_load <= 1'b1;
            o_link_num  <= hdlc_link_q;
            o_link_byte <= i_hdlc_byte;
            hdlc_wait_q <= 1'b0;
        end
    end
end

endmodule // tlpca_core

// ==== tb/tlpca_props.sv ====
// Purpose: port checks of tlpca_core
// Assumes: one clock domain
// Notes:   bound at the foot
module tlpca_props (input logic i_clk, i_rstn, i_cfg_req, o_cfg_ack, o_hdlc_req, o_link_load,
    input logic [31:0] i_link_req, o_link_grant, input logic [7:0] i_fill_byte, o_link_byte);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_oh; $onehot0(o_link_grant); endproperty
    a_oh: assert property (p_oh) else $error("grant not one-hot");
    property p_nul; |o_link_grant [*3] |=> o_link_grant == 0; endproperty
    a_nul: assert property (p_nul) else $error("no null cycle");
    property p_ack; o_cfg_ack |-> o_link_grant == 0 && $past(i_cfg_req); endproperty
    a_ack: assert property (p_ack) else $error("ack outside null");
    property p_gap; o_cfg_ack |=> !o_cfg_ack [*3]; endproperty
    a_gap: assert property (p_gap) else $error("acks too close");
    property p_syn; o_link_grant[0] |-> $past(i_link_req[0], 3); endproperty
    a_syn: assert property (p_syn) else $error("grant before sync");
    property p_lkp; |o_link_grant |=> o_hdlc_req != o_link_load; endproperty
    a_lkp: assert property (p_lkp) else $error("no lookup result");
    property p_req; o_hdlc_req |-> $past(|o_link_grant); endproperty
    a_req: assert property (p_req) else $error("stray request");
    property p_fil; o_link_load && $past(|o_link_grant) |-> o_link_byte == $past(i_fill_byte); endproperty
    a_fil: assert property (p_fil) else $error("bad fill");
endmodule // tlpca_props
bind tlpca_core tlpca_props u_props (.*);

// ==== tb/tlpca_hdlc_model.sv ====
// Purpose: transmit hdlc processor stand-in
// Assumes: one request in flight
// Notes:   byte is channel xor 5a
module tlpca_hdlc_model #(parameter int DLY = 4) (input logic i_clk, o_hdlc_req, input logic [7:0] o_hdlc_chan,
    output logic i_hdlc_valid = 0, output logic [7:0] i_hdlc_byte = 0);
    timeunit 1ns; timeprecision 1ps;
    logic [7:0] c;
    always @(posedge i_clk) if (o_hdlc_req) begin
        c = o_hdlc_chan;
        repeat (DLY) @(negedge i_clk);
        {i_hdlc_valid, i_hdlc_byte} = {1'b1, c ^ 8'h5a};
        @(negedge i_clk);
        {i_hdlc_valid, i_hdlc_byte} = {1'b0, ~i_hdlc_byte};
    end
endmodule // tlpca_hdlc_model

// ==== tb/tlpca_core_bench.sv ====
// Purpose: self-checking bench of tlpca_core
// Assumes: inputs move at the falling edge
// Notes:   hdlc model answers data requests
module tlpca_core_bench;
    timeunit 1ns; timeprecision 1ps;
    logic i_clk = 0, i_rstn = 0, i_cfg_req = 0, i_cfg_wr = 0, o_cfg_ack, o_hdlc_req, o_link_load, i_hdlc_valid;
    logic [31:0] i_link_req = 0, o_link_grant, gq[$];
    logic [159:0] i_link_slot = {32{5'h05}};
    logic [9:0] i_cfg_addr = 0;
    logic [8:0] i_cfg_wdata = 0, o_cfg_rdata;
    logic [7:0] i_fill_byte = 8'hc3, o_hdlc_chan, o_link_byte, i_hdlc_byte;
    logic [4:0] o_link_num;
    logic [12:0] lq[$];
    int num_errors = 0, samples_checked = 0;
    tlpca_core dut (.*);
    tlpca_hdlc_model u_hdlc (.*);
    initial forever #2.5 i_clk = ~i_clk;
    always @(negedge i_clk) begin
        if (o_link_grant !== 0) gq.push_back(o_link_grant);
        if (o_link_load === 1'b1) lq.push_back({o_link_num, o_link_byte});
    end
    task check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task finish_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task cfg(input logic w, input logic [9:0] a, input logic [8:0] d);
        int n;
        {i_cfg_req, i_cfg_wr, i_cfg_addr, i_cfg_wdata} = {1'b1, w, a, d};
        for (n = 0; n < 9 && o_cfg_ack !== 1'b1; n++) @(negedge i_clk);
        i_cfg_req = 0;
        @(negedge i_clk);
        check("ack", n < 9, 1);
    endtask
    task t_prov;
        cfg(1, {5'd3, 5'd5}, 9'h121);
        cfg(1, {5'd0, 5'd5}, 9'h033);
        cfg(1, {5'd7, 5'd5}, 9'h044);
        cfg(1, 10'h3ff, 9'h1ee);
        cfg(0, 10'h3ff, 0);
        check("top word", o_cfg_rdata, 9'h1ee);
    endtask
    task t_arb;
        i_link_req = 32'h89;
        repeat (24) @(negedge i_clk);
        i_link_req = 0;
        check("grants", gq.size(), 3);
        check("grant 0", gq[0], 32'h1);
        check("grant 1", gq[1], 32'h8);
        check("grant 2", gq[2], 32'h80);
        check("load 0", lq[0], {5'd0, 8'hc3});
        check("load 1", lq[1], {5'd7, 8'hc3});
        check("load 2", lq[2], {5'd3, 8'h7b});
    endtask
    initial begin
        repeat (6) @(negedge i_clk);
        i_rstn = 1;
        repeat (4) @(negedge i_clk);
        t_prov;
        t_arb;
        finish_test;
    end
    initial begin
        #5000;
        num_errors++;
        finish_test;
    end
endmodule // tlpca_core_bench
